// ==== hw/urfc_fifo.sv ====
/*
 * Flip-flop FIFO with valid/ready on both sides, synchronous clear and fill count.
 * Assumes one clock and a synchronous active-low reset shared with its user.
 */
`timescale 1ns/1ps

module urfc_fifo
	import urfc_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = 32
)(
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       clr_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [W-1:0]               in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [W-1:0]                    out_data_o,
	output logic [$clog2(DEPTH+1)-1:0]      count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] cnt_r;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_r != CW'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign count_o     = cnt_r;
	assign push        = in_valid_i && in_ready_o && !clr_i;
	assign pop         = out_valid_o && out_ready_i && !clr_i;

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || clr_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

endmodule : urfc_fifo

// ==== hw/urfc_top.sv ====
/*
 * Serial port register block: sub-bank register map, FIFO control, baud generator,
 * transmitter and receiver. Assumes a CPU that drives one-cycle read/write strobes
 * on CLK_I and a serial line that is asynchronous to CLK_I.
 */
// Function
// R01 - LSB first on transmit and receive
// R02 - address 2: write FIFO control, read ident
// R03 - FIFO enable bit switches buffering mode
// R04 - other FIFO control bits need enable set
// R05 - changing FIFO enable empties both FIFOs
// R06 - receive flush bit empties receive FIFO
// R07 - transmit flush bit empties transmit FIFO
// R08 - bits 7:6 pick trigger 1/4/8/14
// R09 - software writes reserved zero bits zero
// R10 - FIFO-only status bits read zero disabled
// R11 - don't-care bits accept writes, no effect
// R12 - FIFO control bits 5:3 reserved
// R13 - interrupt enable bits 0,1,2 gate sources
// R14 - ident bit 0 low while interrupt pending
// R15 - receive interrupt at trigger level
// R16 - line status resets with bits 5,6 set
// R17 - divisor select bit maps divisor latch
// R18 - bits 15:8 of every register read zero
`timescale 1ns/1ps

module urfc_top
	import urfc_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
)(
	input  wire logic                     CLK_I,
	input  wire logic                     RST_N_I,
	input  wire logic [`URFC_ADDR_W-1:0]  ADDR_I,
	input  wire logic                     WR_I,
	input  wire logic                     RD_I,
	input  wire logic [15:0]              WDATA_I,
	output logic      [15:0]              RDATA_O,
	input  wire logic                     SIN_I,
	output logic                          SOUT_O,
	output logic                          INT_O
);
	localparam int CW = $clog2(FIFO_DEPTH+1);
	localparam int RW = $bits(urfc_rxchar_t);

	logic [7:0]  div_lo_r, div_hi_r, ien_r, lctl_r, mctl_r, scr_r;
	logic        fifo_en_r;
	logic [1:0]  trig_r;
	logic        oe_r, pe_r, fe_r, bi_r, fifo_err_r;
	logic        tx_holding_empty_flag_int_r, tx_holding_empty_flag_d_r;
	logic [15:0] baud_cnt_r;
	logic        tick;
	logic        sin_s1_r, sin_s2_r, rx_in;

	logic        dsel, wr_data, wr_fcr, rd_data, rd_iir, rd_lsr;
	logic        rx_clr, tx_clr;
	logic [3:0]  iir_id;
	logic [7:0]  iir_val, lsr_val;

	logic               tx_in_ready, tx_out_valid, tx_pop;
	logic [7:0]         tx_out_data;
	logic [CW-1:0]      tx_count;
	logic               rx_in_ready, rx_out_valid, rx_push;
	urfc_rxchar_t       rx_out, rx_char;
	logic [CW-1:0]      rx_count;
	urfc_state_t        tx_st_r, rx_st_r;
	logic [3:0]         tx_sub_r, tx_bit_r, rx_sub_r, rx_bit_r;
	logic [7:0]         tx_sh_r, rx_sh_r;
	logic               tx_par_r, tx_stop2_r, rx_perr_r, rx_done_r;

	function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
		case (sel)
			2'b00:   trig_level = CW'(`URFC_TRIG_1);
			2'b01:   trig_level = CW'(`URFC_TRIG_4);
			2'b10:   trig_level = CW'(`URFC_TRIG_8);
			default: trig_level = CW'(`URFC_TRIG_14);
		endcase
	endfunction : trig_level

	function automatic logic [3:0] data_bits(input logic [1:0] wls);
		data_bits = 4'h5 + {2'b00, wls};
	endfunction : data_bits

	assign dsel    = lctl_r[`URFC_LCR_DIVSEL];
	assign wr_data = WR_I && ADDR_I == `URFC_ADDR_DATA && !dsel; // R17
	assign rd_data = RD_I && ADDR_I == `URFC_ADDR_DATA && !dsel; // R17
	assign wr_fcr  = WR_I && ADDR_I == `URFC_ADDR_IDFC; // R02
	assign rd_iir  = RD_I && ADDR_I == `URFC_ADDR_IDFC; // R02
	assign rd_lsr  = RD_I && ADDR_I == `URFC_ADDR_LSTAT;

	// a write that toggles the enable flushes both sides; explicit flushes need enable
	assign rx_clr = wr_fcr && ((WDATA_I[`URFC_FCR_EN] != fifo_en_r) || // R05
		(WDATA_I[`URFC_FCR_EN] && WDATA_I[`URFC_FCR_RXCLR])); // R04 R06
	assign tx_clr = wr_fcr && ((WDATA_I[`URFC_FCR_EN] != fifo_en_r) || // R05
		(WDATA_I[`URFC_FCR_EN] && WDATA_I[`URFC_FCR_TXCLR])); // R04 R07

	// character mode keeps one entry: with enable clear the FIFOs are only ever filled to depth one
	assign tx_pop  = tx_st_r == URFC_IDLE && tx_out_valid;
	assign rx_push = rx_done_r && rx_in_ready && (fifo_en_r || rx_count == '0); // R03

	urfc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.clr_i       (tx_clr),
		.in_valid_i  (wr_data && tx_in_ready && (fifo_en_r || tx_count == '0)), // R03
		.in_ready_o  (tx_in_ready),
		.in_data_i   (WDATA_I[7:0]),
		.out_valid_o (tx_out_valid),
		.out_ready_i (tx_st_r == URFC_IDLE),
		.out_data_o  (tx_out_data),
		.count_o     (tx_count)
	);

	urfc_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.clr_i       (rx_clr),
		.in_valid_i  (rx_push),
		.in_ready_o  (rx_in_ready),
		.in_data_i   (rx_char),
		.out_valid_o (rx_out_valid),
		.out_ready_i (rd_data),
		.out_data_o  (rx_out),
		.count_o     (rx_count)
	);

	// interrupt identification, priority line status > data available > tx empty
	always_comb
	begin
		if (ien_r[`URFC_IER_LSTAT] && (oe_r || pe_r || fe_r || bi_r)) // R13
			iir_id = `URFC_IIR_LSTAT;
		else if (ien_r[`URFC_IER_RXAV] && (fifo_en_r ? // R13
			rx_count >= trig_level(trig_r) : rx_out_valid)) // R15
			iir_id = `URFC_IIR_RXAV;
		else if (ien_r[`URFC_IER_TX_HOLDING_EMPTY_FLAG] && tx_holding_empty_flag_int_r) // R13
			iir_id = `URFC_IIR_TX_HOLDING_EMPTY_FLAG;
		else
			iir_id = `URFC_IIR_NONE; // R14
		iir_val = {{2{fifo_en_r}}, 2'b00, iir_id}; // R10
		lsr_val = {fifo_err_r && fifo_en_r, tx_out_valid == 1'b0 && tx_st_r == URFC_IDLE, // R10
			!tx_out_valid, bi_r, fe_r, pe_r, oe_r, rx_out_valid};
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			div_lo_r <= 8'(`URFC_DIV_RST);
			div_hi_r <= 8'(`URFC_DIV_RST >> 8);
			ien_r    <= 8'h00;
			lctl_r   <= 8'h00;
			mctl_r   <= 8'h00;
			scr_r    <= 8'h00;
		end
		else if (WR_I)
		begin
			case (ADDR_I)
				`URFC_ADDR_DATA:      if (dsel) div_lo_r <= WDATA_I[7:0]; // R17
				`URFC_ADDR_IEN:       if (dsel) div_hi_r <= WDATA_I[7:0]; // R17
						else ien_r <= {5'h00, WDATA_I[2:0]}; // R09
				`URFC_ADDR_DIVLO_ALT: div_lo_r <= WDATA_I[7:0];
				`URFC_ADDR_DIVHI_ALT: div_hi_r <= WDATA_I[7:0];
				`URFC_ADDR_LCTL:      lctl_r <= WDATA_I[7:0];
				`URFC_ADDR_MCTL:      mctl_r <= {3'h0, WDATA_I[4], 4'h0}; // R11 R09
				`URFC_ADDR_SCR:       scr_r <= WDATA_I[7:0];
				default:              ; // R11
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			fifo_en_r <= 1'b0;
			trig_r    <= 2'b00;
		end
		else if (wr_fcr)
		begin
			fifo_en_r <= WDATA_I[`URFC_FCR_EN]; // R03
			if (WDATA_I[`URFC_FCR_EN]) // R04 R12
				trig_r <= WDATA_I[`URFC_FCR_TRIG_HI:`URFC_FCR_TRIG_LO]; // R08
		end
	end

	// read data is registered; high byte is always zero
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			RDATA_O <= 16'h0000;
		else if (RD_I)
		begin
			case (ADDR_I)
				`URFC_ADDR_DATA:      RDATA_O <= {8'h00, dsel ? div_lo_r : rx_out.data}; // R18
				`URFC_ADDR_IEN:       RDATA_O <= {8'h00, dsel ? div_hi_r : ien_r}; // R18
				`URFC_ADDR_DIVLO_ALT: RDATA_O <= {8'h00, div_lo_r};
				`URFC_ADDR_DIVHI_ALT: RDATA_O <= {8'h00, div_hi_r};
				`URFC_ADDR_IDFC:      RDATA_O <= {8'h00, iir_val}; // R02
				`URFC_ADDR_LCTL:      RDATA_O <= {8'h00, lctl_r};
				`URFC_ADDR_MCTL:      RDATA_O <= {8'h00, mctl_r};
				`URFC_ADDR_LSTAT:     RDATA_O <= {8'h00, lsr_val};
				`URFC_ADDR_SCR:       RDATA_O <= {8'h00, scr_r};
				default:              RDATA_O <= 16'h0000; // R11 R18
			endcase
		end
	end

	// line status flags: a new error in the cycle of the read wins over the clear
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			{oe_r, pe_r, fe_r, bi_r, fifo_err_r} <= 5'h00; // R16
		end
		else
		begin
			oe_r       <= (rx_done_r && !rx_push) || (oe_r && !rd_lsr);
			pe_r       <= (rx_push && rx_char.par_err) || (pe_r && !rd_lsr);
			fe_r       <= (rx_push && rx_char.frm_err) || (fe_r && !rd_lsr);
			bi_r       <= (rx_push && rx_char.brk) || (bi_r && !rd_lsr);
			fifo_err_r <= (rx_push && fifo_en_r && (rx_char.par_err || rx_char.frm_err ||
				rx_char.brk)) || (fifo_err_r && !rd_lsr && !rx_clr);
		end
	end

	// tx-empty interrupt: set on FIFO draining, cleared by ident read or data write
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			tx_holding_empty_flag_d_r   <= 1'b1;
			tx_holding_empty_flag_int_r <= 1'b0;
			INT_O      <= 1'b0;
		end
		else
		begin
			tx_holding_empty_flag_d_r   <= !tx_out_valid;
			tx_holding_empty_flag_int_r <= (!tx_out_valid && (!tx_holding_empty_flag_d_r || (WR_I && ADDR_I == `URFC_ADDR_IEN
				&& !dsel && WDATA_I[`URFC_IER_TX_HOLDING_EMPTY_FLAG] && !ien_r[`URFC_IER_TX_HOLDING_EMPTY_FLAG])))
				|| (tx_holding_empty_flag_int_r && !wr_data && !(rd_iir && iir_id == `URFC_IIR_TX_HOLDING_EMPTY_FLAG));
			INT_O      <= iir_id != `URFC_IIR_NONE; // R14
		end
	end

	// 16x reference tick from the divisor latch; divisor zero behaves as one
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I || tick)
			baud_cnt_r <= 16'h0000;
		else
			baud_cnt_r <= baud_cnt_r + 16'h0001;
	end
	assign tick = (baud_cnt_r + 16'h0001) >= {div_hi_r, div_lo_r};

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			tx_st_r    <= URFC_IDLE;
			tx_sub_r   <= 4'h0;
			tx_bit_r   <= 4'h0;
			tx_sh_r    <= 8'h00;
			tx_par_r   <= 1'b0;
			tx_stop2_r <= 1'b0;
			SOUT_O     <= 1'b1;
		end
		else
		begin
			SOUT_O <= lctl_r[`URFC_LCR_BRK] ? 1'b0 : (tx_st_r == URFC_START) ? 1'b0 :
				(tx_st_r == URFC_DATA) ? tx_sh_r[0] : // R01
				(tx_st_r == URFC_PAR) ? tx_par_r : 1'b1;
			case (tx_st_r)
				URFC_IDLE:
				begin
					if (tx_pop)
					begin
						tx_sh_r  <= tx_out_data;
						tx_par_r <= lctl_r[`URFC_LCR_STICK] ? !lctl_r[`URFC_LCR_EPS] :
							(^(tx_out_data & (8'hFF >> (2'd3 - lctl_r[1:0]))) ^
							!lctl_r[`URFC_LCR_EPS]);
						tx_sub_r <= 4'h0;
						tx_st_r  <= URFC_START;
					end
				end
				default:
				begin
					if (tick)
					begin
						tx_sub_r <= tx_sub_r + 4'h1;
						if (tx_sub_r == `URFC_OVERSAMPLE_LAST)
						begin
							tx_bit_r <= tx_bit_r + 4'h1;
							case (tx_st_r)
								URFC_START:
								begin
									tx_st_r  <= URFC_DATA;
									tx_bit_r <= 4'h0;
								end
								URFC_DATA:
								begin
									tx_sh_r <= {1'b0, tx_sh_r[7:1]}; // R01
									if (tx_bit_r == data_bits(lctl_r[1:0]) - 4'h1)
										tx_st_r <= lctl_r[`URFC_LCR_PEN] ? URFC_PAR : URFC_STOP;
									tx_stop2_r <= lctl_r[`URFC_LCR_STB];
								end
								URFC_PAR:
									tx_st_r <= URFC_STOP;
								default:
								begin
									tx_stop2_r <= 1'b0;
									if (!tx_stop2_r)
										tx_st_r <= URFC_IDLE;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			sin_s1_r <= 1'b1;
			sin_s2_r <= 1'b1;
		end
		else
		begin
			sin_s1_r <= SIN_I;
			sin_s2_r <= sin_s1_r;
		end
	end
	assign rx_in = mctl_r[`URFC_MCR_LOOP] ? SOUT_O : sin_s2_r;

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			rx_st_r   <= URFC_IDLE;
			rx_sub_r  <= 4'h0;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_perr_r <= 1'b0;
			rx_done_r <= 1'b0;
			rx_char   <= '0;
		end
		else
		begin
			rx_done_r <= 1'b0;
			case (rx_st_r)
				URFC_IDLE:
				begin
					rx_sub_r <= 4'h0;
					if (!rx_in)
						rx_st_r <= URFC_START;
				end
				URFC_START:
				begin
					if (tick)
					begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == `URFC_MID_BIT)
						begin
							rx_st_r   <= rx_in ? URFC_IDLE : URFC_DATA;
							rx_sub_r  <= 4'h0;
							rx_bit_r  <= 4'h0;
							rx_perr_r <= 1'b0;
						end
					end
				end
				default:
				begin
					if (tick)
					begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == `URFC_OVERSAMPLE_LAST)
						begin
							case (rx_st_r)
								URFC_DATA:
								begin
									rx_sh_r  <= {rx_in, rx_sh_r[7:1]}; // R01
									rx_bit_r <= rx_bit_r + 4'h1;
									if (rx_bit_r == data_bits(lctl_r[1:0]) - 4'h1)
										rx_st_r <= lctl_r[`URFC_LCR_PEN] ? URFC_PAR : URFC_STOP;
								end
								URFC_PAR:
								begin
									rx_perr_r <= rx_in != tx_par_of(rx_sh_r);
									rx_st_r   <= URFC_STOP;
								end
								default:
								begin
									rx_char.data    <= rx_sh_r >> (4'h8 - data_bits(lctl_r[1:0]));
									rx_char.par_err <= rx_perr_r;
									rx_char.frm_err <= !rx_in;
									rx_char.brk     <= !rx_in && rx_sh_r == 8'h00;
									rx_done_r       <= 1'b1;
									rx_st_r         <= URFC_IDLE;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// expected parity over the received bits, same sense as the transmitter
	function automatic logic tx_par_of(input logic [7:0] sh);
		tx_par_of = lctl_r[`URFC_LCR_STICK] ? !lctl_r[`URFC_LCR_EPS] :
			((^(sh >> (4'h8 - data_bits(lctl_r[1:0])))) ^ !lctl_r[`URFC_LCR_EPS]);
	endfunction : tx_par_of

endmodule : urfc_top

// ==== shared/urfc_defs.svh ====
/*
 * Address map, field positions, reset values and trigger counts of the serial port
 * register block. Included by the package and the port checker; definitions only.
 */
`ifndef URFC_DEFS_SVH
`define URFC_DEFS_SVH

`define URFC_ADDR_W          4
`define URFC_ADDR_DATA       4'h0
`define URFC_ADDR_IEN        4'h1
`define URFC_ADDR_IDFC       4'h2
`define URFC_ADDR_LCTL       4'h3
`define URFC_ADDR_MCTL       4'h4
`define URFC_ADDR_LSTAT      4'h5
`define URFC_ADDR_RSVD       4'h6
`define URFC_ADDR_SCR        4'h7
`define URFC_ADDR_DIVLO_ALT  4'h8
`define URFC_ADDR_DIVHI_ALT  4'h9

`define URFC_FCR_EN          0
`define URFC_FCR_RXCLR       1
`define URFC_FCR_TXCLR       2
`define URFC_FCR_TRIG_LO     6
`define URFC_FCR_TRIG_HI     7

`define URFC_IER_RXAV        0
`define URFC_IER_TX_HOLDING_EMPTY_FLAG        1
`define URFC_IER_LSTAT       2

`define URFC_LCR_STB         2
`define URFC_LCR_PEN         3
`define URFC_LCR_EPS         4
`define URFC_LCR_STICK       5
`define URFC_LCR_BRK         6
`define URFC_LCR_DIVSEL      7
`define URFC_MCR_LOOP        4

`define URFC_LSR_RST         8'h60
`define URFC_DIV_RST         16'h0001
`define URFC_IIR_NONE        4'h1
`define URFC_IIR_LSTAT       4'h6
`define URFC_IIR_RXAV        4'h4
`define URFC_IIR_TX_HOLDING_EMPTY_FLAG        4'h2

`define URFC_TRIG_1          5'h01
`define URFC_TRIG_4          5'h04
`define URFC_TRIG_8          5'h08
`define URFC_TRIG_14         5'h0E

`define URFC_OVERSAMPLE_LAST 4'hF
`define URFC_MID_BIT         4'h7

`endif

// ==== shared/urfc_pkg.sv ====
/*
 * Types of the serial port register block: state encodings and the received
 * character carrier. Assumes urfc_defs.svh is reachable on the include path.
 */
`include "urfc_defs.svh"

package urfc_pkg;

	typedef enum logic [4:0] {
		URFC_IDLE  = 5'h01,
		URFC_START = 5'h02,
		URFC_DATA  = 5'h04,
		URFC_PAR   = 5'h08,
		URFC_STOP  = 5'h10
	} urfc_state_t;

	typedef struct packed {
		logic       brk;
		logic       frm_err;
		logic       par_err;
		logic [7:0] data;
	} urfc_rxchar_t;

endpackage : urfc_pkg

// ==== test/test_uart_register_map_fifo_control.sv ====
/* Self-checking bench for the serial port register block with a serial peer.
   Assumes the design, the checker and urfc_peer are compiled before this file. */
`timescale 1ns/1ps

module test_uart_register_map_fifo_control
	import urfc_pkg::*;
;
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr  = 4'h0;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        sin;
	logic        sout;
	logic        irq;
	int          n_errors = 0;
	int          n_tests  = 0;

	always #50 clk = ~clk;

	// depth 16 keeps the 14-byte trigger reachable while staying small
	urfc_top #(.FIFO_DEPTH(16)) u_dut (
		.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
		.WDATA_I(wdata), .RDATA_O(rdata), .SIN_I(sin), .SOUT_O(sout), .INT_O(irq)
	);
	urfc_peer #(.BIT_CLKS(16)) u_peer (.clk_i(clk), .sout_i(sout), .sin_o(sin));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus_wr

	task automatic rc(input logic [3:0] a, input logic [15:0] exp);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		check(rdata, exp);
	endtask : rc

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// traffic needs about 6000 cycles; the limit leaves wide margin
	initial
	begin : watchdog
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test();
	end

	initial
	begin : main
		logic [15:0] r;
		logic [7:0]  b;
		logic [7:0]  exp_q[$];
		logic [7:0]  tx_q[$];
		int          trig[4];
		trig = '{1, 4, 8, 14};
		r = $urandom(45);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rc(4'h5, 16'h0060);
		rc(4'h2, 16'h0001);
		bus_wr(4'h3, 16'h0083);
		r = $urandom;
		bus_wr(4'h0, r);
		bus_wr(4'h1, ~r);
		rc(4'h8, r & 16'h00FF);
		rc(4'h1, ~r & 16'h00FF);
		bus_wr(4'h8, 16'h0001);
		rc(4'h8, 16'h0001);
		bus_wr(4'h9, 16'h0000);
		rc(4'h9, 16'h0000);
		bus_wr(4'h3, 16'h0003);
		bus_wr(4'h1, 16'hFF01);
		rc(4'h1, 16'h0001);
		r = $urandom;
		bus_wr(4'h7, r);
		rc(4'h7, r & 16'h00FF);
		bus_wr(4'h6, ~r);
		rc(4'h7, r & 16'h00FF);
		rc(4'h5, 16'h0060);
		bus_wr(4'h2, 16'h00C6);
		rc(4'h2, 16'h0001);
		bus_wr(4'h2, 16'h0001);
		rc(4'h2, 16'h00C1);
		for (int k = 0; k < 4; k++)
		begin
			bus_wr(4'h2, 16'(k * 64 + 3));
			exp_q.delete();
			for (int j = 0; j < trig[k]; j++)
			begin
				if (j == trig[k] - 1)
				begin
					repeat (24) @(posedge clk);
					rc(4'h2, 16'h00C1);
				end
				b = $urandom;
				exp_q.push_back(b);
				u_peer.send(b);
			end
			repeat (24) @(posedge clk);
			check({15'h0000, irq}, 16'h0001);
			rc(4'h2, 16'h00C4);
			rc(4'h0, {8'h00, exp_q.pop_front()});
			bus_wr(4'h2, 16'(k * 64 + 3));
			rc(4'h5, 16'h0060);
			rc(4'h2, 16'h00C1);
		end
		b = $urandom;
		u_peer.send(b);
		repeat (24) @(posedge clk);
		bus_wr(4'h2, 16'h0000);
		rc(4'h5, 16'h0060);
		rc(4'h2, 16'h0001);
		bus_wr(4'h2, 16'h0001);
		// byte 0 is already shifting when the flush lands, bytes 1 to 3 are not
		for (int i = 0; i < 6; i++)
		begin
			b = $urandom;
			if (i == 4)
				bus_wr(4'h2, 16'h0005);
			if (i == 0 || i > 3)
				tx_q.push_back(b);
			bus_wr(4'h0, {8'h00, b});
			if (i == 0)
				repeat (24) @(posedge clk);
		end
		repeat (700) @(posedge clk);
		check(16'(u_peer.rx_q.size()), 16'h0003);
		while (tx_q.size() > 0)
			check({8'h00, u_peer.rx_q.pop_front()}, {8'h00, tx_q.pop_front()});
		rc(4'h5, 16'h0060);
		bus_wr(4'h1, 16'h0003);
		rc(4'h2, 16'h00C2);
		rc(4'h2, 16'h00C1);
		// parity expected but the peer sends none: its stop bit is taken as bad parity
		bus_wr(4'h3, 16'h000B);
		bus_wr(4'h1, 16'h0005);
		u_peer.send(8'h01);
		repeat (40) @(posedge clk);
		rc(4'h2, 16'h00C6);
		rc(4'h5, 16'h00E5);
		rc(4'h5, 16'h0061);
		rc(4'h2, 16'h00C4);
		rc(4'h0, 16'h0001);
		rc(4'h2, 16'h00C1);
		stop_test();
	end
endmodule : test_uart_register_map_fifo_control

// ==== test/urfc_peer.sv ====
/* Far-end serial device: sends frames into the port and captures what it sends.
   Assumes 8 data bits, no parity, one stop bit and a fixed bit length in clocks. */
`timescale 1ns/1ps

module urfc_peer
	import urfc_pkg::*;
#(
	parameter int BIT_CLKS = 16
)(
	input  wire logic clk_i,
	input  wire logic sout_i,
	output logic      sin_o
);
	logic [7:0] rx_q[$];

	// line idles high between frames, as a pulled-up receive line would
	initial
		sin_o = 1'b1;

	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i);
			sin_o <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
	endtask : send

	// samples mid-bit so a few clocks of skew against the port do no harm
	always
	begin : capture
		logic [7:0] b;
		@(negedge sout_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge clk_i);
			b[i] = sout_i;
		end
		repeat (BIT_CLKS) @(posedge clk_i);
		rx_q.push_back(b);
	end
endmodule : urfc_peer

// ==== test/urfc_top_assertions.sv ====
/* Port checker for the serial port register block, bound to every urfc_top.
   Assumes a divisor of at least 1 and an idle cycle after every bus strobe. */
`timescale 1ns/1ps
`include "urfc_defs.svh"

module urfc_top_assertions
	import urfc_pkg::*;
(
	input wire logic                    CLK_I,
	input wire logic                    RST_N_I,
	input wire logic [`URFC_ADDR_W-1:0] ADDR_I,
	input wire logic                    WR_I,
	input wire logic                    RD_I,
	input wire logic [15:0]             WDATA_I,
	input wire logic [15:0]             RDATA_O,
	input wire logic                    SIN_I,
	input wire logic                    SOUT_O,
	input wire logic                    INT_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	a_hi_zero: assert property (RDATA_O[15:8] == 8'h00)
		else $error("read data upper byte not zero");
	a_rdata_hold: assert property (!RD_I |=> $stable(RDATA_O))
		else $error("read data moved without a read");
	a_reset_quiet: assert property (disable iff (1'b0)
		!RST_N_I |=> RDATA_O == 16'h0000 && SOUT_O && !INT_O)
		else $error("outputs not quiet during reset");
	a_ident_shape: assert property (
		RD_I && !WR_I && ADDR_I == 4'h2 |=> RDATA_O[5:3] == 3'h0 && RDATA_O[7] == RDATA_O[6])
		else $error("ident read has bad fixed bits");
	a_fifo_on: assert property (
		WR_I && ADDR_I == 4'h2 && WDATA_I[0] ##2 RD_I && !WR_I && ADDR_I == 4'h2
		|=> RDATA_O[7:6] == 2'h3)
		else $error("fifo enable not shown in ident");
	a_fifo_off: assert property (
		WR_I && ADDR_I == 4'h2 && !WDATA_I[0] ##2 RD_I && !WR_I && ADDR_I == 4'h2
		|=> RDATA_O[7:6] == 2'h0)
		else $error("fifo bits set while disabled");
	a_ident_pend: assert property (
		RD_I && !WR_I && ADDR_I == 4'h2 ##1 INT_O && !RD_I ##1 INT_O |-> RDATA_O[0] == 1'b0)
		else $error("ident says idle while interrupt stands");
	a_start_len: assert property ($fell(SOUT_O) |-> !SOUT_O [*8] ##1 !SOUT_O [*8])
		else $error("start bit shorter than sixteen ticks");
	a_scratch_rb: assert property (
		WR_I && ADDR_I == 4'h7 ##2 RD_I && !WR_I && ADDR_I == 4'h7
		|=> RDATA_O == ($past(WDATA_I, 3) & 16'h00FF))
		else $error("scratch read back wrong");
	a_div_rb: assert property (
		WR_I && ADDR_I == 4'h8 ##2 RD_I && !WR_I && ADDR_I == 4'h8
		|=> RDATA_O == ($past(WDATA_I, 3) & 16'h00FF))
		else $error("divisor low read back wrong");

	c_rx_int: cover property (RD_I && ADDR_I == 4'h2 ##1 INT_O);
	c_tx_frame: cover property ($fell(SOUT_O));
	c_rx_flush: cover property (WR_I && ADDR_I == 4'h2 && WDATA_I[1:0] == 2'h3);
endmodule : urfc_top_assertions

bind urfc_top urfc_top_assertions u_chk (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
	.WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .SIN_I(SIN_I), .SOUT_O(SOUT_O), .INT_O(INT_O)
);
